// ==== verilog/ddscw_decoder.sv ====
// Serial control word decoder and oscillator core.
// Assumes the serial pins are asynchronous to ref_clk and that the
// serial clock runs well below a quarter of ref_clk.
`include "ddscw_map.svh"

// Functional notes
// (RULE1) Power-down bit set turns the DAC off; clear keeps it on.
// (RULE2) MSB-output bit set routes DAC data MSB, direct or halved, to pin.
// (RULE3) MSB-output bit clear routes the DAC to the pin, sine or ramp.
// (RULE4) MSB mode: no-halving bit 1 passes MSB, 0 passes MSB divided by two.
// (RULE5) Waveform bit 1 gives ramp from phase; 0 gives sine lookup. The code computes a parabolic sine with no table.
// (RULE6) Writer keeps waveform bit 0 while MSB output is enabled.
// (RULE7) Writer writes zero into reserved control bits D4, D2, D0.
// (RULE8) Two 28-bit tuning words; tuning select picks word 0 or 1.
// (RULE9) Two 12-bit offsets; offset select picks which is added.
// (RULE10) Accumulator adds selected tuning word every clock.
// (RULE11) Output phase shifts by offset times two pi over 4096.
// (RULE12) Address 01 writes tuning word 0, 10 tuning word 1, 14 bits.
// (RULE13) Address 00 writes the control bits.
// (RULE14) Full-word mode: two writes to one address, low half then high.
// (RULE15) Split mode: each write changes only one 14-bit half.
// (RULE16) Split mode: half select 1 is high half, 0 low half.
// (RULE17) Full-word mode: word changes only once both halves arrived.
// (RULE18) Address 11 writes offset word chosen by D13, low 12 bits.
// (RULE19) One 16-bit word per frame, MSB first, acted on after 16 bits.
module ddscw_decoder (
  // Clock and reset
  input  wire logic              ref_clk,
  input  wire logic              rst_b,
  // Serial load pins
  input  wire logic              serial_clk_in,
  input  wire logic              serial_data_in,
  input  wire logic              load_frame_b,
  // Towards the analog output pin
  output ddscw_pkg::ddscw_out_t  analog_output_pin
);

  ddscw_pkg::ddscw_state_t     q;
  ddscw_pkg::ddscw_state_t     next_q;
  logic                        sclk_fall;
  logic                        frame_start;
  logic                        load;
  logic [`DDSCW_WORD_BITS-1:0] word;
  logic [`DDSCW_PH_W-1:0]      phase;
  logic [`DDSCW_DAC_W-1:0]     ramp_code;
  logic [`DDSCW_DAC_W-1:0]     sine_code;
  logic [`DDSCW_DAC_W-1:0]     wave_code;
  logic [21:0]                 prod;
  logic [`DDSCW_DAC_W-1:0]     amp;
  logic [`DDSCW_PH_W-2:0]      x;

  // ----------------------------------------------------------
  // Serial framing
  // ----------------------------------------------------------
  // Edge detectors look only at the second sync stage.
  assign sclk_fall   = q.sclk_prev & ~q.sclk_sync[1];
  assign frame_start = q.frame_prev_b & ~q.frame_sync_b[1];
  assign load = ~q.frame_sync_b[1] & sclk_fall
              & (q.cnt == `DDSCW_BIT_LAST); // RULE19
  assign word = {q.shift, q.serial_data_in_sync[1]};

  // ----------------------------------------------------------
  // Waveform generation
  // ----------------------------------------------------------
  // Offset adds into the top 12 bits, one step = 2*pi/4096.
  assign phase = q.acc[`DDSCW_ACC_W-1 -: `DDSCW_PH_W]
               + q.ow[q.ctl.offset_select]; // RULE9 RULE11
  assign ramp_code = phase[`DDSCW_PH_W-1] ?
                     ~phase[`DDSCW_PH_W-2:1] : phase[`DDSCW_PH_W-2:1];
  // Parabolic sine: cheap, no table, a few percent of distortion.
  assign x    = phase[`DDSCW_PH_W-2:0];
  assign prod = 22'(x) * (22'h000800 - 22'(x));
  assign amp  = (prod[21:11] > 11'(`DDSCW_AMP_MAX)) ?
                `DDSCW_AMP_MAX : prod[20:11];
  assign sine_code = phase[`DDSCW_PH_W-1] ?
                     `DDSCW_MID - amp : `DDSCW_MID + amp;
  assign wave_code = q.ctl.wave_ramp ? ramp_code : sine_code; // RULE5

  // ----------------------------------------------------------
  // Next state
  // ----------------------------------------------------------
  always_comb begin
    next_q = q;
    next_q.sclk_sync    = {q.sclk_sync[0], serial_clk_in};
    next_q.serial_data_in_sync   = {q.serial_data_in_sync[0], serial_data_in};
    next_q.frame_sync_b = {q.frame_sync_b[0], load_frame_b};
    next_q.sclk_prev    = q.sclk_sync[1];
    next_q.frame_prev_b = q.frame_sync_b[1];

    // Bits beyond the sixteenth are ignored until the frame ends.
    if (frame_start || q.frame_sync_b[1]) begin
      next_q.cnt = `DDSCW_RST_CNT; // RULE19
    end else if (sclk_fall && q.cnt <= `DDSCW_BIT_LAST) begin
      next_q.shift = word[`DDSCW_WORD_BITS-2:0];
      next_q.cnt   = q.cnt + 5'h01;
    end

    if (load) begin
      case (word[15:14])
        `DDSCW_ADR_CTL: begin
          next_q.ctl  = ddscw_pkg::ddscw_ctl_t'(word); // RULE13
          next_q.pend = 1'b0;
        end
        `DDSCW_ADR_TW0, `DDSCW_ADR_TW1: begin
          // Address 01 maps to word 0, address 10 to word 1.
          if (q.ctl.full_word_load) begin
            if (q.pend && q.pend_idx == word[15]) begin
              next_q.tw[word[15]] = {word[13:0], q.pend_low}; // RULE14
              next_q.pend         = 1'b0; // RULE17
            end else begin
              next_q.pend     = 1'b1; // RULE17
              next_q.pend_idx = word[15];
              next_q.pend_low = word[13:0]; // RULE14
            end
          end else if (q.ctl.half_select) begin
            next_q.tw[word[15]][27:14] = word[13:0]; // RULE15 RULE16
          end else begin
            next_q.tw[word[15]][13:0] = word[13:0]; // RULE12 RULE16
          end
        end
        `DDSCW_ADR_OFS: begin
          next_q.ow[word[13]] = word[11:0]; // RULE18
        end
        default: begin
          next_q.pend = q.pend;
        end
      endcase
    end

    next_q.acc = q.acc + q.tw[q.ctl.tuning_select]; // RULE10 RULE8

    // Halved MSB: toggles once per full period of the MSB.
    next_q.msb_prev = wave_code[`DDSCW_DAC_W-1];
    if (wave_code[`DDSCW_DAC_W-1] && !q.msb_prev) begin
      next_q.msb_half = ~q.msb_half;
    end
    next_q.out.dac_active = ~q.ctl.dac_powerdown; // RULE1
    next_q.out.dac_to_pin = ~q.ctl.msb_output_enable; // RULE2 RULE3
    next_q.out.dac_code   = wave_code; // RULE3
    next_q.out.msb_bit    = q.ctl.msb_no_halving ?
                            wave_code[`DDSCW_DAC_W-1] : // RULE4
                            q.msb_half;
  end

  // ----------------------------------------------------------
  // State register
  // ----------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      next_q_reset : begin
        q              <= '0;
        // Serial clock idles high; starting high avoids a false fall
        q.sclk_sync    <= 2'h3;
        q.sclk_prev    <= 1'h1;
        q.serial_data_in_sync   <= 2'h0;
        q.frame_sync_b <= 2'h3;
        q.frame_prev_b <= 1'b1;
        q.cnt          <= `DDSCW_RST_CNT;
        q.ctl          <= ddscw_pkg::ddscw_ctl_t'(`DDSCW_RST_CTL);
        q.tw           <= {`DDSCW_RST_TW, `DDSCW_RST_TW};
        q.ow           <= {`DDSCW_RST_OW, `DDSCW_RST_OW};
        q.pend_low     <= `DDSCW_RST_HALF;
        q.acc          <= `DDSCW_RST_TW;
        q.out.dac_active <= 1'b1;
        q.out.dac_to_pin <= 1'b1;
        q.out.dac_code   <= `DDSCW_MID;
      end
    end else begin
      q <= next_q;
    end
  end

  assign analog_output_pin = q.out;

  // ----------------------------------------------------------
  // Checks
  // ----------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_b);

  AST_PWDN: assert property ( // RULE1
    ##1 analog_output_pin.dac_active == !$past(q.ctl.dac_powerdown))
    else $error("DAC power state does not follow control bit");

  AST_ROUTE: assert property ( // RULE2
    ##1 analog_output_pin.dac_to_pin
        == !$past(q.ctl.msb_output_enable))
    else $error("Pin routing does not follow MSB-output bit");

  AST_DIRECT_MSB: assert property ( // RULE4
    q.ctl.msb_no_halving |=>
      analog_output_pin.msb_bit == $past(wave_code[`DDSCW_DAC_W-1]))
    else $error("Direct MSB not passed");

  AST_RAMP: assert property ( // RULE5
    q.ctl.wave_ramp |=> analog_output_pin.dac_code == $past(ramp_code))
    else $error("Ramp content wrong");

  AST_ACC: assert property ( // RULE10
    ##1 q.acc == 28'($past(q.acc) + $past(q.tw[q.ctl.tuning_select])))
    else $error("Accumulator did not advance by selected word");

  AST_CTL: assert property ( // RULE13
    load && word[15:14] == `DDSCW_ADR_CTL |=> q.ctl == $past(word))
    else $error("Control word not stored");

  AST_SPLIT: assert property ( // RULE15
    load && word[15:14] == `DDSCW_ADR_TW0 && !q.ctl.full_word_load
    |=> (q.ctl.half_select ? $stable(q.tw[0][13:0])
                           : $stable(q.tw[0][27:14])))
    else $error("Split write touched the other half");

  AST_FULL_HOLD: assert property ( // RULE17
    load && word[15:14] == `DDSCW_ADR_TW1 && q.ctl.full_word_load
    && !(q.pend && q.pend_idx) |=> $stable(q.tw[1]) && q.pend)
    else $error("Tuning word changed on first half");

  AST_OFS: assert property ( // RULE18
    load && word[15:14] == `DDSCW_ADR_OFS && !word[13]
    |=> q.ow[0] == $past(word[11:0]))
    else $error("Offset word 0 not loaded");

  AST_LOAD: assert property ( // RULE19
    !load |=> $stable(q.ctl) && $stable(q.tw) && $stable(q.ow))
    else $error("Register changed without a complete word");

  // ----------------------------------------------------------
  // Checks on word loading
  // ----------------------------------------------------------

  AST_OFS1: assert property ( // RULE18
    load && word[15:14] == `DDSCW_ADR_OFS && word[13]
    |=> q.ow[1] == $past(word[11:0]))
    else $error("Offset word 1 not loaded");

  AST_OFS_KEEP: assert property ( // RULE9
    load && word[15:14] == `DDSCW_ADR_OFS && !word[13]
    |=> $stable(q.ow[1]))
    else $error("Offset word 1 changed by a write to word 0");

  AST_FULL_HOLD0: assert property ( // RULE17
    load && word[15:14] == `DDSCW_ADR_TW0 && q.ctl.full_word_load
    && !(q.pend && !q.pend_idx) |=> $stable(q.tw[0]) && q.pend)
    else $error("Tuning word 0 changed on first half");

  AST_FULL_DONE: assert property ( // RULE14
    load && word[15:14] == `DDSCW_ADR_TW0 && q.ctl.full_word_load
    && q.pend && !q.pend_idx
    |=> q.tw[0] == {$past(word[13:0]), $past(q.pend_low)} && !q.pend)
    else $error("Tuning word 0 not loaded from both halves");

  AST_SPLIT1: assert property ( // RULE15
    load && word[15:14] == `DDSCW_ADR_TW1 && !q.ctl.full_word_load
    |=> (q.ctl.half_select ? $stable(q.tw[1][13:0])
                           : $stable(q.tw[1][27:14])))
    else $error("Split write touched the other half of word 1");

  AST_HALF_HI: assert property ( // RULE16
    load && word[15:14] == `DDSCW_ADR_TW1 && !q.ctl.full_word_load
    && q.ctl.half_select |=> q.tw[1][27:14] == $past(word[13:0]))
    else $error("High half of word 1 not written");

  AST_HALF_LO: assert property ( // RULE12
    load && word[15:14] == `DDSCW_ADR_TW1 && !q.ctl.full_word_load
    && !q.ctl.half_select |=> q.tw[1][13:0] == $past(word[13:0]))
    else $error("Low half of word 1 not written");

  AST_CTL_PEND: assert property ( // RULE13
    load && word[15:14] == `DDSCW_ADR_CTL |=> !q.pend)
    else $error("Control write left a half word pending");

  AST_CUT: assert property ( // RULE19
    q.frame_sync_b[1] |=> q.cnt == `DDSCW_RST_CNT)
    else $error("Bit count not cleared outside a frame");

  // ----------------------------------------------------------
  // Checks on the oscillator and the output selection
  // ----------------------------------------------------------

  AST_TSEL0: assert property ( // RULE8
    !q.ctl.tuning_select |=> q.acc == $past(q.acc) + $past(q.tw[0]))
    else $error("Word 0 not used while tuning select is 0");

  AST_TSEL1: assert property ( // RULE8
    q.ctl.tuning_select |=> q.acc == $past(q.acc) + $past(q.tw[1]))
    else $error("Word 1 not used while tuning select is 1");

  AST_SINE: assert property ( // RULE5
    !q.ctl.wave_ramp |=> analog_output_pin.dac_code == $past(sine_code))
    else $error("Sine content wrong");

  AST_DAC_OUT: assert property ( // RULE3
    !q.ctl.msb_output_enable |=> analog_output_pin.dac_to_pin
    && analog_output_pin.dac_code == $past(wave_code))
    else $error("DAC content not routed to the pin");

  AST_HALVED: assert property ( // RULE4
    !q.ctl.msb_no_halving |=>
      analog_output_pin.msb_bit == $past(q.msb_half))
    else $error("Halved MSB not passed");

  AST_HALF_TOGGLE: assert property ( // RULE4
    wave_code[`DDSCW_DAC_W-1] && !q.msb_prev
    |=> q.msb_half != $past(q.msb_half))
    else $error("Halved MSB did not toggle on a rising MSB");

endmodule

// ==== common/ddscw_map.svh ====
// Constant map of the oscillator control word decoder.
// Assumes inclusion by the package and the decoder only.
`ifndef DDSCW_MAP_SVH
`define DDSCW_MAP_SVH
// ------------------------------------------------------------
// Word addresses (top two bits of each serial word)
// ------------------------------------------------------------
`define DDSCW_ADR_CTL   2'h0
`define DDSCW_ADR_TW0   2'h1
`define DDSCW_ADR_TW1   2'h2
`define DDSCW_ADR_OFS   2'h3
// ------------------------------------------------------------
// Widths and counts
// ------------------------------------------------------------
`define DDSCW_WORD_BITS 16
`define DDSCW_BIT_LAST  5'h0f
`define DDSCW_ACC_W     28
`define DDSCW_HALF_W    14
`define DDSCW_PH_W      12
`define DDSCW_DAC_W     10
// ------------------------------------------------------------
// Reset values and amplitude constants
// ------------------------------------------------------------
`define DDSCW_RST_CTL   16'h0000
`define DDSCW_RST_TW    28'h0000000
`define DDSCW_RST_OW    12'h000
`define DDSCW_RST_HALF  14'h0000
`define DDSCW_RST_CNT   5'h00
`define DDSCW_MID       10'h200
`define DDSCW_AMP_MAX   10'h1ff
`endif

// ==== common/ddscw_pkg.sv ====
// Types shared by the control word decoder and its bench.
// Assumes ddscw_map.svh is on the include path.
`include "ddscw_map.svh"
package ddscw_pkg;
  // ----------------------------------------------------------
  // Control word, laid out bit for bit as it arrives
  // ----------------------------------------------------------
  typedef struct packed {
    logic [1:0] adr;
    logic       full_word_load;
    logic       half_select;
    logic       tuning_select;
    logic       offset_select;
    logic [2:0] upper_rsv;
    logic       dac_powerdown;
    logic       msb_output_enable;
    logic       rsv4;
    logic       msb_no_halving;
    logic       rsv2;
    logic       wave_ramp;
    logic       rsv0;
  } ddscw_ctl_t;
  // ----------------------------------------------------------
  // Output bundle towards the analog output pin
  // ----------------------------------------------------------
  typedef struct packed {
    logic                      dac_active;
    logic                      dac_to_pin;
    logic                      msb_bit;
    logic [`DDSCW_DAC_W-1:0]   dac_code;
  } ddscw_out_t;
  // ----------------------------------------------------------
  // Whole state of the decoder
  // ----------------------------------------------------------
  typedef struct packed {
    logic [1:0]                     sclk_sync;
    logic [1:0]                     serial_data_in_sync;
    logic [1:0]                     frame_sync_b;
    logic                           sclk_prev;
    logic                           frame_prev_b;
    logic [`DDSCW_WORD_BITS-2:0]    shift;
    logic [4:0]                     cnt;
    ddscw_ctl_t                     ctl;
    logic [1:0][`DDSCW_ACC_W-1:0]   tw;
    logic [1:0][`DDSCW_PH_W-1:0]    ow;
    logic                           pend;
    logic                           pend_idx;
    logic [`DDSCW_HALF_W-1:0]       pend_low;
    logic [`DDSCW_ACC_W-1:0]        acc;
    logic                           msb_prev;
    logic                           msb_half;
    ddscw_out_t                     out;
  } ddscw_state_t;
endpackage

// ==== test/ddscw_host.sv ====
// Host model that shifts 16-bit words into the decoder's serial pins.
// Assumes ref_clk is the decoder clock; pin edges land 1 ns after it.
module ddscw_host (
  // Core clock, used only to place the pin edges
  input  wire logic ref_clk,
  // Serial load pins
  output logic      serial_clk_in,
  output logic      serial_data_in,
  output logic      load_frame_b
);
  timeunit 1ns;
  timeprecision 1ns;

  initial begin
    serial_clk_in  = 1'b1;
    serial_data_in = 1'b0;
    load_frame_b   = 1'b1;
  end

  // ------------------------------------------------------------
  // Frame of n bits, MSB first; n below 16 makes a cut-short frame
  // ------------------------------------------------------------
  task automatic send(input logic [15:0] w, input int n);
    @(posedge ref_clk);
    #1 load_frame_b = 1'b0;
    for (int i = 15; i > 15 - n; i--) begin
      serial_data_in = w[i];
      #200 serial_clk_in = 1'b0;
      #200 serial_clk_in = 1'b1;
    end
    // Undriven data line shows the inverse, never a stale bit
    #200 serial_data_in = ~serial_data_in;
    load_frame_b = 1'b1;
    #400;
  endtask
endmodule

// ==== test/tb_top.sv ====
// Self-checking bench for the control word decoder.
// Assumes ddscw_pkg is compiled first and ddscw_host drives the pins.
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;

  logic                  ref_clk;
  logic                  rst_b;
  logic                  serial_clk_in;
  logic                  serial_data_in;
  logic                  load_frame_b;
  ddscw_pkg::ddscw_out_t pin;
  int                    miscompares = 0;
  int                    comparisons = 0;
  int                    cycles = 0;

  ddscw_decoder uut (
    .ref_clk(ref_clk), .rst_b(rst_b), .serial_clk_in(serial_clk_in),
    .serial_data_in(serial_data_in), .load_frame_b(load_frame_b),
    .analog_output_pin(pin));
  ddscw_host host (
    .ref_clk(ref_clk), .serial_clk_in(serial_clk_in),
    .serial_data_in(serial_data_in), .load_frame_b(load_frame_b));

  initial begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end

  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  function automatic logic [9:0] ramp(input logic [11:0] ph);
    return ph[11] ? ~ph[10:1] : ph[10:1];
  endfunction
  // f = full, half, tsel, osel, pdown, msb_en, no_halving, ramp
  function automatic logic [15:0] ctl(input logic [7:0] f);
    return {2'h0, f[7:4], 3'h0, f[3:2], 1'h0, f[1], 1'h0, f[0],
            1'h0};
  endfunction
  task automatic tick();
    @(posedge ref_clk);
    #1;
  endtask
  task automatic wr(input logic [15:0] w);
    host.send(w, 16);
    repeat (8) tick();
  endtask
  task automatic chk_code(input logic [9:0] got, input logic [9:0] exp);
    comparisons++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chk_bit(input logic got, input logic exp);
    comparisons++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Ramp advancing 2 phase steps a clock moves the code by 0, +1 or -1
  task automatic run_check(input logic moving);
    logic [9:0] prev;
    logic [9:0] d;
    int         moves;
    logic       ok;
    moves = 0;
    ok = 1'b1;
    tick();
    prev = pin.dac_code;
    repeat (40) begin
      tick();
      d = pin.dac_code - prev;
      prev = pin.dac_code;
      if (d !== 10'h000) moves++;
      if (d !== 10'h000 && d !== 10'h001 && d !== 10'h3ff) ok = 1'b0;
    end
    chk_bit(ok && (moving ? moves >= 30 : moves == 0), 1'b1);
  endtask
  task automatic count_msb(output int n);
    logic p;
    n = 0;
    tick();
    p = pin.msb_bit;
    repeat (256) begin
      tick();
      if (pin.msb_bit !== p) n++;
      p = pin.msb_bit;
    end
  endtask
  task automatic print_verdict();
    $display("comparisons=%0d miscompares=%0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // Generous ceiling: the sequence needs under 8000 cycles
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 30000) begin
      miscompares++;
      print_verdict();
    end
  end

  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    logic [11:0] o0;
    logic [11:0] o1;
    logic [9:0]  held;
    int          n1;
    int          n2;
    rst_b = 1'b0;
    void'($urandom(81));
    repeat (12) tick();
    rst_b = 1'b1;
    repeat (4) tick();
    chk_bit(pin.dac_active, 1'b1);
    chk_bit(pin.dac_to_pin, 1'b1);
    for (int i = 0; i < 4; i++) begin
      o0 = (i == 0) ? 12'h000 : 12'($urandom);
      o1 = (i == 0) ? 12'hfff : 12'($urandom);
      wr({4'hc, o0});
      wr({4'he, o1});
      wr(ctl(8'h01));
      chk_code(pin.dac_code, ramp(o0));
      wr(ctl(8'h11));
      chk_code(pin.dac_code, ramp(o1));
    end
    wr({4'hc, 12'h000});
    wr(ctl(8'h00));
    chk_code(pin.dac_code, 10'h200);
    wr({4'hc, 12'h400});
    chk_bit(pin.dac_code >= 10'h3f0, 1'b1);
    held = pin.dac_code;
    host.send({4'hc, 12'h800}, 8);
    repeat (8) tick();
    chk_code(pin.dac_code, held);
    wr(ctl(8'h81));
    wr(16'h4000);
    wr(16'h4008);
    run_check(1'b1);
    wr(16'hbfff);
    run_check(1'b1);
    wr(ctl(8'h21));
    run_check(1'b0);
    wr(ctl(8'h61));
    wr(16'h8008);
    run_check(1'b1);
    wr(ctl(8'h21));
    wr(16'h8000);
    wr(16'h4000);
    run_check(1'b1);
    wr(ctl(8'h61));
    wr(16'h8200);
    // MSB output keeps the waveform bit clear
    wr(ctl(8'h2e));
    chk_bit(pin.dac_to_pin, 1'b0);
    chk_bit(pin.dac_active, 1'b0);
    count_msb(n1);
    chk_bit(n1 >= 15 && n1 <= 17, 1'b1);
    wr(ctl(8'h24));
    chk_bit(pin.dac_active, 1'b1);
    count_msb(n2);
    chk_bit(n2 >= 7 && n2 <= 9, 1'b1);
    wr(ctl(8'h21));
    chk_bit(pin.dac_to_pin, 1'b1);
    print_verdict();
  end
endmodule
